// >>> design/hscd_top.sv
// Strap capture and decode of a four-port hub's power-on configuration
`timescale 1ns/100ps
// Behaviour
// [RULE_01] Both serial straps pulled up: SMBus slave
// [RULE_02] Data-out pulled down: UART, TX/RX pins
// [RULE_03] No serial straps: enter SPI, seek ROM
// [RULE_04] SPI without valid ROM falls to bridging
// [RULE_05] ROM valid only with signature at address
// [RULE_06] Never enable conflicting interface pairs together
// [RULE_07] SMBus slave only in configuration 1,2,3,6
// [RULE_08] Bridging needs mode 1,2,3,6 and host setup
// [RULE_09] Shared pin roles follow the serial mode
// [RULE_10] Per-line disable straps, one means disabled
// [RULE_11] Port off only when both lines disabled
// [RULE_12] Fixed-port strap decodes five resistor options
// [RULE_13] Charge strap decodes same five options
// [RULE_14] Mode strap decodes six resistor options
// [RULE_15] Capture straps at reset release, hold
// [RULE_16] Encoded levels mapped through tables, registered
module hscd_top
   import hscd_pkg::*;
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_arst_n,
   // Encoded strap levels from the analog detector
   input wire logic [2:0] i_fixed_port_strap,
   input wire logic [2:0] i_charge_port_strap,
   input wire logic [2:0] i_mode_strap,
   input wire logic [2:0] i_dout_strap,
   input wire logic [2:0] i_clk_strap,
   input wire logic [3:0] i_port_plus_disable,
   input wire logic [3:0] i_port_minus_disable,
   // ROM search result from the SPI reader
   input wire logic i_rom_done,
   input wire logic i_rom_valid,
   // Host has programmed the bridge registers
   input wire logic i_bridge_setup,
   // Serial mode and enables
   output logic [1:0] o_serial_pin_mode_cfg,
   output logic o_spi_en,
   output logic o_smbus_en,
   output logic o_bridge_en,
   output logic o_uart_en,
   output logic o_rom_search,
   output logic o_straps_valid,
   // Shared pin roles
   output logic o_pin_straps_active,
   output logic o_slave_cfg_active,
   output logic [1:0] o_slave_cfg,
   // Port settings
   output logic [3:0] o_plus_off,
   output logic [3:0] o_minus_off,
   output logic [3:0] o_port_off,
   output logic [3:0] o_fixed_ports,
   output logic [3:0] o_charge_ports,
   output logic [2:0] o_device_mode,
   output logic o_mode_error
);
   hscd_strap_if s();        // Synchronised strap codes
   hscd_state_t state;       // Capture sequencer
   hscd_ser_t ser_mode;      // Held serial mode
   logic [2:0] mode_cfg;     // Held device mode
   logic mode_ok;            // Held mode-valid flag
   logic sideband_ok;        // Mode maps pins 4 and 5 to sideband data and clock

   hscd_sync u_sync (
      .i_clock(i_clock),
      .i_arst_n(i_arst_n),
      .i_fixed_code(i_fixed_port_strap),
      .i_charge_code(i_charge_port_strap),
      .i_mode_code(i_mode_strap),
      .i_dout_code(i_dout_strap),
      .i_clk_code(i_clk_strap),
      .i_plus_dis(i_port_plus_disable),
      .i_minus_dis(i_port_minus_disable),
      .o_s(s)
   );

   // Five-option port count table, thermometer of ports 1 upward
   function automatic logic [3:0] port_table(input logic [2:0] code);
      case (code)
         HSCD_RES_200K_DN: port_table = 4'h0;
         HSCD_RES_200K_UP: port_table = 4'h1;
         HSCD_RES_10K_DN: port_table = 4'h3;
         HSCD_RES_10K_UP: port_table = 4'h7;
         HSCD_RES_10R_DN: port_table = 4'hf;
         default: port_table = 4'h0;   // Unlisted level: safest setting
      endcase
   endfunction

   // Six-option device mode table; bit 3 flags a listed level
   function automatic logic [3:0] mode_table(input logic [2:0] code);
      case (code)
         HSCD_RES_200K_DN: mode_table = {1'b1, HSCD_CFG_MIXED};
         HSCD_RES_200K_UP: mode_table = {1'b1, HSCD_CFG_PORTSWAP};
         HSCD_RES_10K_DN: mode_table = {1'b1, HSCD_CFG_SPEED};
         HSCD_RES_10K_UP: mode_table = {1'b1, HSCD_CFG_GPIO};
         HSCD_RES_10R_DN: mode_table = {1'b1, HSCD_CFG_CHARGE};
         HSCD_RES_10R_UP: mode_table = {1'b1, HSCD_CFG_UART};
         default: mode_table = {1'b0, HSCD_CFG_MIXED};
      endcase
   endfunction

   // Sequencer: capture two cycles after the synchroniser fills, then wait for ROM when both serial straps are absent
   // The three-cycle settle keeps reset-era zeros out of the capture.
   logic [1:0] settle;
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         settle <= 2'h0;
      end else if (settle != HSCD_SETTLE_END) begin
         settle <= settle + 2'h1;
      end
   end

   // Capture strobe: synchroniser full and sequencer still idle
   // Shared by every capture process so they all latch on one edge
   logic capture_now;
   assign capture_now = state == HSCD_ST_IDLE && settle == HSCD_SETTLE_END;

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state <= HSCD_ST_IDLE;
      end else begin
         case (state)
            HSCD_ST_IDLE: begin
               if (capture_now) begin
                  if (s.dout_code == HSCD_RES_NONE && s.clk_code == HSCD_RES_NONE) begin
                     state <= HSCD_ST_ROM;   // [RULE_03]
                  end else begin
                     state <= HSCD_ST_DONE;
                  end
               end
            end
            HSCD_ST_ROM: begin
               if (i_rom_done) begin
                  state <= HSCD_ST_DONE;
               end
            end
            HSCD_ST_DONE: state <= HSCD_ST_DONE;   // Held until next reset
            default: state <= HSCD_ST_IDLE;
         endcase
      end
   end

   // Serial mode choice; a 10K pull-down on data-out wins as UART
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ser_mode <= hscd_ser_t'(HSCD_RST_SER);
      end else if (capture_now) begin
         if (s.dout_code == HSCD_RES_10K_DN) begin
            ser_mode <= HSCD_SER_UART;   // [RULE_02]
         end else if (s.dout_code == HSCD_RES_10K_UP && s.clk_code == HSCD_RES_10K_UP) begin
            ser_mode <= HSCD_SER_SMBUS;   // [RULE_01]
         end else begin
            ser_mode <= HSCD_SER_SPI;   // [RULE_03]
         end
      end else if (state == HSCD_ST_ROM && i_rom_done && !i_rom_valid) begin
         ser_mode <= HSCD_SER_BRIDGE;   // [RULE_04] [RULE_05]
      end
   end

   // Mode and port straps latched once at capture
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         mode_cfg <= HSCD_RST_CFG;
         mode_ok <= 1'b0;
         o_fixed_ports <= HSCD_RST_MASK;
         o_charge_ports <= HSCD_RST_MASK;
         o_plus_off <= HSCD_RST_MASK;
         o_minus_off <= HSCD_RST_MASK;
         o_port_off <= HSCD_RST_MASK;
      end else if (capture_now) begin
         {mode_ok, mode_cfg} <= mode_table(s.mode_code);   // [RULE_14] [RULE_15] [RULE_16]
         o_fixed_ports <= port_table(s.fixed_code);   // [RULE_12]
         o_charge_ports <= port_table(s.charge_code);   // [RULE_13]
         o_plus_off <= s.plus_dis;   // [RULE_10]
         o_minus_off <= s.minus_dis;   // [RULE_10]
         o_port_off <= s.plus_dis & s.minus_dis;   // [RULE_11]
      end
   end

   // Sideband pins exist only outside configurations 4 and 5
   assign sideband_ok = mode_cfg != HSCD_CFG_GPIO && mode_cfg != HSCD_CFG_CHARGE;

   // Registered enables; one-hot on mode so forbidden pairs cannot occur
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_spi_en <= 1'b0;
         o_smbus_en <= 1'b0;
         o_bridge_en <= 1'b0;
         o_uart_en <= 1'b0;
         o_rom_search <= 1'b0;
         o_straps_valid <= 1'b0;
         o_serial_pin_mode_cfg <= HSCD_RST_SER;
         o_device_mode <= HSCD_RST_CFG;
         o_mode_error <= 1'b0;
      end else begin
         o_rom_search <= state == HSCD_ST_ROM;   // [RULE_03]
         o_straps_valid <= state == HSCD_ST_DONE;   // [RULE_15]
         o_serial_pin_mode_cfg <= ser_mode;
         o_device_mode <= mode_cfg;
         o_mode_error <= state == HSCD_ST_DONE && !mode_ok;
         o_spi_en <= ser_mode == HSCD_SER_SPI && state != HSCD_ST_IDLE;   // [RULE_06]
         o_uart_en <= ser_mode == HSCD_SER_UART && state == HSCD_ST_DONE;   // [RULE_06]
         o_smbus_en <= ser_mode == HSCD_SER_SMBUS && state == HSCD_ST_DONE
                       && sideband_ok;   // [RULE_07] [RULE_06]
         o_bridge_en <= ser_mode == HSCD_SER_BRIDGE && state == HSCD_ST_DONE
                        && sideband_ok && i_bridge_setup;   // [RULE_08] [RULE_06]
      end
   end

   // Shared pin roles: straps on first two unless SPI, slave config only in SMBus
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_pin_straps_active <= 1'b0;
         o_slave_cfg_active <= 1'b0;
         o_slave_cfg <= 2'h0;
      end else begin
         o_pin_straps_active <= ser_mode != HSCD_SER_SPI && state == HSCD_ST_DONE;   // [RULE_09]
         o_slave_cfg_active <= ser_mode == HSCD_SER_SMBUS && state == HSCD_ST_DONE;   // [RULE_09]
         // Pulled-up data-out and clock read as ones in slave mode
         o_slave_cfg <= (ser_mode == HSCD_SER_SMBUS && state == HSCD_ST_DONE) ? 2'h3 : 2'h0;
      end
   end
endmodule

// >>> design/hscd_pkg.sv
// Package of strap encodings, modes and timing for the strap configuration decoder
package hscd_pkg;
   // Resistor level code delivered by the analog strap detector
   typedef enum logic [2:0] {
      HSCD_RES_NONE = 3'h0,   // No resistor found
      HSCD_RES_200K_DN = 3'h1,
      HSCD_RES_200K_UP = 3'h2,
      HSCD_RES_10K_DN = 3'h3,
      HSCD_RES_10K_UP = 3'h4,
      HSCD_RES_10R_DN = 3'h5,
      HSCD_RES_10R_UP = 3'h6
   } hscd_res_t;

   // Shared serial pin modes
   typedef enum logic [1:0] {
      HSCD_SER_SPI = 2'h0,
      HSCD_SER_SMBUS = 2'h1,
      HSCD_SER_BRIDGE = 2'h2,
      HSCD_SER_UART = 2'h3
   } hscd_ser_t;

   // Device modes, configuration 1 to 6
   typedef enum logic [2:0] {
      HSCD_CFG_MIXED = 3'h1,
      HSCD_CFG_PORTSWAP = 3'h2,
      HSCD_CFG_SPEED = 3'h3,
      HSCD_CFG_GPIO = 3'h4,
      HSCD_CFG_CHARGE = 3'h5,
      HSCD_CFG_UART = 3'h6
   } hscd_cfg_t;

   // Sequencer states, Gray along capture, wait ROM, done
   typedef enum logic [1:0] {
      HSCD_ST_IDLE = 2'b00,
      HSCD_ST_ROM = 2'b01,
      HSCD_ST_DONE = 2'b11
   } hscd_state_t;

   // Reset values of captured settings
   localparam logic [3:0] HSCD_RST_MASK = 4'h0;
   localparam logic [2:0] HSCD_RST_CFG = 3'h1;
   localparam logic [1:0] HSCD_RST_SER = 2'h0;
   // Last count of the post-reset settle counter; capture follows it
   localparam logic [1:0] HSCD_SETTLE_END = 2'h3;
   // Boot ROM signature address (signature itself is checked by the ROM reader)
   localparam logic [15:0] HSCD_SIG_ADDR = 16'hfffa;
   // Number of downstream ports
   localparam int HSCD_PORTS = 4;
endpackage

// >>> design/hscd_strap_if.sv
// Interface carrying synchronised raw strap codes between decoder modules
`timescale 1ns/100ps
interface hscd_strap_if;
   logic [2:0] fixed_code;   // Non-removable strap level
   logic [2:0] charge_code;  // Battery charging strap level
   logic [2:0] mode_code;    // Device mode strap level
   logic [2:0] dout_code;    // Serial data-out strap level
   logic [2:0] clk_code;     // Serial clock strap level
   logic [3:0] plus_dis;     // Plus-line disable straps
   logic [3:0] minus_dis;    // Minus-line disable straps
   modport src (output fixed_code, charge_code, mode_code, dout_code, clk_code,
                output plus_dis, minus_dis);
   modport dst (input fixed_code, charge_code, mode_code, dout_code, clk_code,
                input plus_dis, minus_dis);
endinterface

// >>> design/hscd_sync.sv
// Two-stage synchroniser for the strap inputs from the pins
`timescale 1ns/100ps
module hscd_sync
   import hscd_pkg::*;
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_arst_n,
   // Raw strap levels
   input wire logic [2:0] i_fixed_code,
   input wire logic [2:0] i_charge_code,
   input wire logic [2:0] i_mode_code,
   input wire logic [2:0] i_dout_code,
   input wire logic [2:0] i_clk_code,
   input wire logic [3:0] i_plus_dis,
   input wire logic [3:0] i_minus_dis,
   // Synchronised side
   hscd_strap_if.src o_s
);
   // First stage, read only by the second stage
   logic [22:0] meta;
   // Second stage
   logic [22:0] sync;

   // Both stages on one edge; no logic taps the first stage
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         meta <= 23'h0;
         sync <= 23'h0;
      end else begin
         meta <= {i_fixed_code, i_charge_code, i_mode_code, i_dout_code, i_clk_code,
                  i_plus_dis, i_minus_dis};
         sync <= meta;
      end
   end

   assign o_s.fixed_code = sync[22:20];
   assign o_s.charge_code = sync[19:17];
   assign o_s.mode_code = sync[16:14];
   assign o_s.dout_code = sync[13:11];
   assign o_s.clk_code = sync[10:8];
   assign o_s.plus_dis = sync[7:4];
   assign o_s.minus_dis = sync[3:0];
endmodule

// >>> sim/hscd_top_assertions.sv
// Checker of the strap decoder's port-level relations, bound to its top module
`timescale 1ns/100ps
module hscd_top_assertions
   import hscd_pkg::*;
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_arst_n,
   // Inputs that gate the search and the bridge
   input wire logic i_bridge_setup,
   input wire logic i_rom_done,
   input wire logic i_rom_valid,
   // Serial mode and enables
   input wire logic [1:0] o_serial_pin_mode_cfg,
   input wire logic o_spi_en,
   input wire logic o_smbus_en,
   input wire logic o_bridge_en,
   input wire logic o_uart_en,
   input wire logic o_rom_search,
   input wire logic o_straps_valid,
   // Shared pin roles
   input wire logic o_pin_straps_active,
   input wire logic o_slave_cfg_active,
   // Port settings
   input wire logic [3:0] o_plus_off,
   input wire logic [3:0] o_minus_off,
   input wire logic [3:0] o_port_off,
   input wire logic [3:0] o_fixed_ports,
   input wire logic [3:0] o_charge_ports,
   input wire logic [2:0] o_device_mode
);
   // One clock domain, so clock and reset are given once
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_arst_n);

   mutex_ifs_a: assert property (!(o_uart_en && (o_smbus_en || o_spi_en))
      && !(o_smbus_en && o_bridge_en)) else $error("conflicting interfaces enabled");
   smbus_gate_a: assert property (o_smbus_en |->
      o_serial_pin_mode_cfg == HSCD_SER_SMBUS && !(o_device_mode inside {3'h4, 3'h5}))
      else $error("sideband slave enabled wrongly");
   bridge_gate_a: assert property (o_bridge_en |-> $past(i_bridge_setup)
      && o_serial_pin_mode_cfg == HSCD_SER_BRIDGE && !(o_device_mode inside {3'h4, 3'h5}))
      else $error("bridge enabled wrongly");
   port_pair_a: assert property (o_port_off == (o_plus_off & o_minus_off))
      else $error("port off not both lines");
   thermo_code_a: assert property (
      o_fixed_ports inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf}
      && o_charge_ports inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf}) else $error("port set not a run");
   pin_role_a: assert property (o_straps_valid |->
      o_pin_straps_active == (o_serial_pin_mode_cfg != HSCD_SER_SPI)
      && o_slave_cfg_active == (o_serial_pin_mode_cfg == HSCD_SER_SMBUS))
      else $error("shared pin roles wrong");
   hold_cfg_a: assert property (o_straps_valid |=> o_straps_valid
      && $stable(o_device_mode) && $stable(o_serial_pin_mode_cfg) && $stable(o_port_off))
      else $error("settings moved");
   search_spi_a: assert property (o_rom_search |->
      o_serial_pin_mode_cfg == HSCD_SER_SPI && !o_straps_valid) else $error("search outside spi");
   rom_fall_a: assert property (o_rom_search && i_rom_done && !i_rom_valid |->
      ##[1:2] o_serial_pin_mode_cfg == HSCD_SER_BRIDGE) else $error("no fallback to bridge");
   rom_keep_a: assert property (o_rom_search && i_rom_done && i_rom_valid |->
      ##2 o_serial_pin_mode_cfg == HSCD_SER_SPI) else $error("valid rom left spi");
endmodule
bind hscd_top hscd_top_assertions u_chk (
   .i_clock(i_clock),
   .i_arst_n(i_arst_n),
   .i_bridge_setup(i_bridge_setup),
   .i_rom_done(i_rom_done),
   .i_rom_valid(i_rom_valid),
   .o_serial_pin_mode_cfg(o_serial_pin_mode_cfg),
   .o_spi_en(o_spi_en),
   .o_smbus_en(o_smbus_en),
   .o_bridge_en(o_bridge_en),
   .o_uart_en(o_uart_en),
   .o_rom_search(o_rom_search),
   .o_straps_valid(o_straps_valid),
   .o_pin_straps_active(o_pin_straps_active),
   .o_slave_cfg_active(o_slave_cfg_active),
   .o_plus_off(o_plus_off),
   .o_minus_off(o_minus_off),
   .o_port_off(o_port_off),
   .o_fixed_ports(o_fixed_ports),
   .o_charge_ports(o_charge_ports),
   .o_device_mode(o_device_mode)
);

// >>> sim/hscd_far_side.sv
// Boot ROM model answering the decoder's ROM search after a set delay
`timescale 1ns/100ps
module hscd_far_side (
   // Clock and search request
   input wire logic i_clock,
   input wire logic i_rom_search,
   // Answer delay and whether the signature is present
   input wire logic [2:0] i_dly,
   input wire logic i_sig_ok,
   // Search result
   output logic o_rom_done,
   output logic o_rom_valid
);
   int cnt = 0; // Cycles spent searching
   initial o_rom_done = 1'b0;
   initial o_rom_valid = 1'b0;
   // Validity toggles outside the answer so a stale value is never trusted
   // An unknown search request before reset counts as no request
   always @(posedge i_clock) begin
      if (i_rom_search !== 1'b1) begin
         cnt <= 0;
         o_rom_done <= 1'b0;
         o_rom_valid <= ~o_rom_valid;
      end else if (cnt == i_dly) begin
         o_rom_done <= 1'b1;
         o_rom_valid <= i_sig_ok;
         cnt <= cnt + 1;
      end else begin
         o_rom_done <= 1'b0;
         o_rom_valid <= ~o_rom_valid;
         if (cnt < i_dly) cnt <= cnt + 1;
      end
   end
endmodule

// >>> sim/tb.sv
// Testbench walking strap combinations through reset captures of the decoder
`timescale 1ns/100ps
module tb;
   import hscd_pkg::*;
   // Design inputs, all given a value at time zero
   logic i_clock = 1'b0, i_arst_n = 1'b0, i_bridge_setup = 1'b0, sig_ok = 1'b0;
   logic [2:0] i_fixed_port_strap = 3'h0, i_charge_port_strap = 3'h0, i_mode_strap = 3'h0;
   logic [2:0] i_dout_strap = 3'h0, i_clk_strap = 3'h0, dly = 3'h0;
   logic [3:0] i_port_plus_disable = 4'h0, i_port_minus_disable = 4'h0;
   logic i_rom_done, i_rom_valid;
   // Design outputs
   logic [1:0] o_serial_pin_mode_cfg, o_slave_cfg;
   logic o_spi_en, o_smbus_en, o_bridge_en, o_uart_en, o_rom_search, o_straps_valid;
   logic o_pin_straps_active, o_slave_cfg_active, o_mode_error;
   logic [3:0] o_plus_off, o_minus_off, o_port_off, o_fixed_ports, o_charge_ports;
   logic [2:0] o_device_mode;
   int err_total = 0, n_checks = 0;
   // Serial strap table: uart, sideband slave, spi ok, spi no rom, one pull-up only
   localparam logic [2:0] DT[5] = '{3'h3, 3'h4, 3'h0, 3'h0, 3'h4};
   localparam logic [2:0] CT[5] = '{3'h4, 3'h4, 3'h0, 3'h0, 3'h0};

   hscd_top u_dut (
      .i_clock(i_clock),
      .i_arst_n(i_arst_n),
      .i_fixed_port_strap(i_fixed_port_strap),
      .i_charge_port_strap(i_charge_port_strap),
      .i_mode_strap(i_mode_strap),
      .i_dout_strap(i_dout_strap),
      .i_clk_strap(i_clk_strap),
      .i_port_plus_disable(i_port_plus_disable),
      .i_port_minus_disable(i_port_minus_disable),
      .i_rom_done(i_rom_done),
      .i_rom_valid(i_rom_valid),
      .i_bridge_setup(i_bridge_setup),
      .o_serial_pin_mode_cfg(o_serial_pin_mode_cfg),
      .o_spi_en(o_spi_en),
      .o_smbus_en(o_smbus_en),
      .o_bridge_en(o_bridge_en),
      .o_uart_en(o_uart_en),
      .o_rom_search(o_rom_search),
      .o_straps_valid(o_straps_valid),
      .o_pin_straps_active(o_pin_straps_active),
      .o_slave_cfg_active(o_slave_cfg_active),
      .o_slave_cfg(o_slave_cfg),
      .o_plus_off(o_plus_off),
      .o_minus_off(o_minus_off),
      .o_port_off(o_port_off),
      .o_fixed_ports(o_fixed_ports),
      .o_charge_ports(o_charge_ports),
      .o_device_mode(o_device_mode),
      .o_mode_error(o_mode_error)
   );
   hscd_far_side u_rom (.i_clock(i_clock), .i_rom_search(o_rom_search), .i_dly(dly),
      .i_sig_ok(sig_ok), .o_rom_done(i_rom_done), .o_rom_valid(i_rom_valid));

   // 25 MHz clock
   always #20 i_clock = ~i_clock;

   // Ports fixed or charging, as a run from port 1
   function automatic logic [3:0] thermo(input logic [2:0] c);
      case (c)
         3'h2: return 4'h1;
         3'h3: return 4'h3;
         3'h4: return 4'h7;
         3'h5: return 4'hf;
         default: return 4'h0; // All off, also for unlisted codes
      endcase
   endfunction

   task automatic chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic give_verdict();
      if (err_total == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // One capture: straps under reset, release, then scramble straps and check
   task automatic run(input int i, input int j);
      int k;
      logic [2:0] dm;
      logic ok;
      logic srch;
      hscd_ser_t ser;
      k = (i + j * 2) % 5;
      srch = 1'b0;
      @(posedge i_clock);
      i_arst_n <= 1'b0;
      i_fixed_port_strap <= 3'(i);
      i_charge_port_strap <= 3'(i + 3);
      i_mode_strap <= 3'(i);
      i_dout_strap <= DT[k];
      i_clk_strap <= CT[k];
      i_port_plus_disable <= 4'(i * 3);
      i_port_minus_disable <= 4'(i * 5 + j);
      i_bridge_setup <= (j > 0);
      dly <= 3'(i);
      sig_ok <= (k != 3);
      repeat (2) @(posedge i_clock);
      // Reset values while reset is still held
      @(negedge i_clock);
      chk("rst_valid", o_straps_valid, 0);
      chk("rst_mode", o_device_mode, HSCD_RST_CFG);
      @(posedge i_clock);
      i_arst_n <= 1'b1;
      // Poll between edges for the settled flag, noting any ROM search
      for (int n = 0; n < 40 && o_straps_valid !== 1'b1; n++) begin
         @(negedge i_clock);
         if (o_rom_search === 1'b1) srch = 1'b1;
      end
      // Later strap changes must be ignored
      @(posedge i_clock);
      i_fixed_port_strap <= 3'(i + 2);
      i_mode_strap <= 3'h4;
      i_dout_strap <= 3'h3;
      i_port_plus_disable <= ~i_port_plus_disable;
      repeat (4) @(posedge i_clock);
      // Outputs looked at half a cycle after the edge that launches them
      @(negedge i_clock);
      dm = (i >= 1 && i <= 6) ? 3'(i) : 3'h1;
      ok = !(dm inside {3'h4, 3'h5});
      if (DT[k] == 3'h3) ser = HSCD_SER_UART;
      else if (DT[k] == 3'h4 && CT[k] == 3'h4) ser = HSCD_SER_SMBUS;
      else if (k == 3) ser = HSCD_SER_BRIDGE;
      else ser = HSCD_SER_SPI;
      chk("valid", o_straps_valid, 1);
      chk("rom_search", srch, DT[k] == 3'h0 && CT[k] == 3'h0);
      chk("search_end", o_rom_search, 0);
      chk("mode_cfg", o_serial_pin_mode_cfg, ser);
      chk("spi_en", o_spi_en, ser == HSCD_SER_SPI);
      chk("smbus_en", o_smbus_en, ser == HSCD_SER_SMBUS && ok);
      chk("bridge_en", o_bridge_en, ser == HSCD_SER_BRIDGE && ok && j > 0);
      chk("uart_en", o_uart_en, ser == HSCD_SER_UART);
      chk("pin_straps", o_pin_straps_active, ser != HSCD_SER_SPI);
      chk("slave_act", o_slave_cfg_active, ser == HSCD_SER_SMBUS);
      chk("slave_cfg", o_slave_cfg, (ser == HSCD_SER_SMBUS) ? 4'h3 : 4'h0);
      chk("plus_off", o_plus_off, 4'(i * 3));
      chk("minus_off", o_minus_off, 4'(i * 5 + j));
      chk("port_off", o_port_off, 4'(i * 3) & 4'(i * 5 + j));
      chk("fixed", o_fixed_ports, thermo(3'(i)));
      chk("charge", o_charge_ports, thermo(3'(i + 3)));
      chk("dev_mode", o_device_mode, dm);
      chk("mode_err", o_mode_error, !(i >= 1 && i <= 6));
      // Bridge drops one cycle after the host setup goes away
      @(posedge i_clock);
      i_bridge_setup <= 1'b0;
      @(posedge i_clock);
      @(negedge i_clock);
      chk("bridge_off", o_bridge_en, 0);
      chk("mode_hold", o_serial_pin_mode_cfg, ser);
   endtask

   // Every strap code against three of the five serial strap rows, setup off and on
   initial begin
      for (int j = 0; j < 3; j++)
         for (int i = 0; i < 8; i++)
            run(i, j);
      give_verdict();
   end

   // Watchdog well beyond the 24 captures of some 16 to 26 cycles each
   initial begin
      repeat (3000) @(posedge i_clock);
      err_total++;
      give_verdict();
   end
endmodule
